// ### include/bctr_pkg.sv
// constants and carrier types of the bootstrap control and timestamp register bank
package bctr_pkg;
   // register byte addresses (32-bit words, 64-bit registers low word first)
   localparam int unsigned ADR_W = 12;
   localparam logic [11:0] OFS_CFG_LO = 12'h1e0;
   localparam logic [11:0] OFS_CFG_HI = 12'h1e4;
   localparam logic [11:0] OFS_HB_PERIOD = 12'h1e8;
   localparam logic [11:0] OFS_CHAN = 12'h1ec;
   localparam logic [11:0] OFS_TS_LO = 12'h1f0;
   localparam logic [11:0] OFS_TS_HI = 12'h1f4;
   localparam logic [11:0] OFS_LATCH = 12'h1f8;
   localparam logic [11:0] OFS_TICK_LO = 12'h1fc;
   localparam logic [11:0] OFS_TICK_HI = 12'h200;
   localparam logic [11:0] OFS_OWN = 12'h204;
   localparam logic [11:0] OFS_LEGACY = 12'h208;
   localparam logic [11:0] OFS_ENDIAN = 12'h20c;
   // capability bit positions
   localparam int unsigned CAP_OWN_BIT = 1;
   localparam int unsigned CAP_CHAN_BIT = 2;
   localparam int unsigned CAP_TS_BIT = 3;
   localparam int unsigned CAP_ENDIAN_BIT = 10;
   localparam int unsigned CAP_PACKED_BIT = 12;
   localparam logic [63:0] CAP_DEFAULT = 64'h0000_0000_0000_140e;
   // field positions
   localparam int unsigned CFG_HB_BIT = 0;
   localparam int unsigned CFG_PACKED_BIT = 1;
   localparam int unsigned LATCH_BIT = 0;
   localparam int unsigned OWN_W = 3;
   // reset and fixed values
   localparam logic [31:0] HB_PERIOD_RST = 32'h0000_0bb8;
   localparam logic [31:0] CHAN_RST = 32'h0000_0000;
   localparam logic [31:0] ENDIAN_BIG = 32'h0000_0000;
   localparam logic [31:0] ENDIAN_LITTLE = 32'hffff_ffff;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_IN_NS = 1000000;
   localparam int unsigned CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   localparam logic [63:0] TICK_NS = 64'(CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      OWN_AVAILABLE = 3'b000,
      OWN_EXCLUSIVE = 3'b001
   } bctr_own_e;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bctr_bus_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } bctr_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } bctr_wb_rsp_s;
endpackage

// ### test/bctr_host.sv
// host model that issues single classic register accesses to the bank
`timescale 1ns/10ps
`default_nettype none

module bctr_host (
   input wire logic clk_i,
   input wire bctr_pkg::bctr_wb_rsp_s wb_rsp_i,
   output var bctr_pkg::bctr_wb_req_s wb_req_o
);
   initial wb_req_o = '0;

   // request raised after an edge, held until ack is sampled high
   task automatic xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                       input logic [31:0] wdat, output logic [31:0] rdat);
      rdat = 32'h0000_0000;
      if (adr == bctr_pkg::OFS_LEGACY) begin
         return;
      end
      @(posedge clk_i);
      wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wdat};
      @(posedge clk_i);
      while (wb_rsp_i.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      rdat = wb_rsp_i.dat;
      wb_req_o <= '0;
   endtask

   task automatic wr(input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] d);
      logic [31:0] unused;
      xfer(1'b1, adr, sel, d, unused);
   endtask

   task automatic rd(input logic [11:0] adr, output logic [31:0] d);
      xfer(1'b0, adr, 4'hf, 32'h0000_0000, d);
   endtask

   // capture first, then read both words of the held time
   task automatic read_time(output logic [63:0] t);
      logic [31:0] lo;
      logic [31:0] hi;
      wr(bctr_pkg::OFS_LATCH, 4'hf, 32'h0000_0001);
      rd(bctr_pkg::OFS_TS_LO, lo);
      rd(bctr_pkg::OFS_TS_HI, hi);
      t = {hi, lo};
   endtask
endmodule // bctr_host

`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the bootstrap control and timestamp register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   localparam int unsigned CPM = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   bctr_pkg::bctr_wb_req_s wb_req;
   bctr_pkg::bctr_wb_rsp_s wb_rsp;
   logic hb_en, pk_en, link_def;
   logic [31:0] chan;
   logic [2:0] own;
   logic [63:0] dev_t, ta, tb_t, ts;
   logic [31:0] seed = 32'h0001_6809;
   logic [31:0] rd, v;
   int fail_count = 0;
   int n_compared = 0;
   int n_exp = 0;
   int cyc_cnt = 0;
   int k;
   logic [11:0] radr [12] = '{bctr_pkg::OFS_CFG_LO, bctr_pkg::OFS_CFG_HI,
      bctr_pkg::OFS_HB_PERIOD, bctr_pkg::OFS_CHAN, bctr_pkg::OFS_TS_LO, bctr_pkg::OFS_TS_HI,
      bctr_pkg::OFS_LATCH, bctr_pkg::OFS_TICK_LO, bctr_pkg::OFS_TICK_HI, bctr_pkg::OFS_OWN,
      bctr_pkg::OFS_ENDIAN, 12'h100};
   logic [31:0] rexp [12] = '{32'h0000_0000, 32'h0000_0000, bctr_pkg::HB_PERIOD_RST,
      bctr_pkg::CHAN_RST, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0032,
      32'h0000_0000, 32'h0000_0000, bctr_pkg::ENDIAN_LITTLE, 32'h0000_0000};
   logic [11:0] ro_m = 12'b1101_1011_0010;

   always #25 clk_i = ~clk_i;

   bctr_regs #(.CAPABILITY(bctr_pkg::CAP_DEFAULT), .LITTLE_ENDIAN(1'b1), .CYC_PER_MS(CPM))
   bctr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .heartbeat_enable_o(hb_en), .packed_events_enable_o(pk_en),
      .async_channel_number_o(chan), .ownership_state_o(own), .link_defaults_o(link_def),
      .device_time_o(dev_t));

   bctr_host bctr_host_i (.clk_i(clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] exp_cfg(input logic [31:0] w);
      return {30'h0, w[1] & bctr_pkg::CAP_DEFAULT[12], w[0] & bctr_pkg::CAP_DEFAULT[1]};
   endfunction

   function automatic logic [31:0] exp_own(input logic [31:0] w);
      return {29'h0, w[2:0]};
   endfunction

   task automatic chk_w(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_d(input string what, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      if (link_def === 1'b1) begin
         n_exp <= n_exp + 1;
      end
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 2000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, then read-only words must shrug off writes
      for (int i = 0; i < 12; i++) begin
         bctr_host_i.rd(radr[i], rd);
         chk_w("reset value", rexp[i], rd);
         if (ro_m[i]) begin
            bctr_host_i.wr(radr[i], 4'hf, 32'h5a5a_a5a5);
            bctr_host_i.rd(radr[i], rd);
            chk_w("read-only word", rexp[i], rd);
         end
      end
      v = 32'hffff_ffff;
      bctr_host_i.wr(bctr_pkg::OFS_CFG_LO, 4'hf, v);
      bctr_host_i.rd(bctr_pkg::OFS_CFG_LO, rd);
      chk_w("config", exp_cfg(v), rd);
      chk_w("enables", 32'h0000_0003, {30'h0, hb_en, pk_en});
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v = seed | 32'h0000_0001; // nonzero channel
         bctr_host_i.wr(bctr_pkg::OFS_CHAN, 4'hf, v);
         bctr_host_i.rd(bctr_pkg::OFS_CHAN, rd);
         chk_w("channel", v, rd);
         chk_w("channel out", v, chan);
         seed = lfsr(seed);
         bctr_host_i.wr(bctr_pkg::OFS_OWN, 4'hf, seed);
         bctr_host_i.rd(bctr_pkg::OFS_OWN, rd);
         chk_w("ownership", exp_own(seed), rd);
         chk_w("ownership out", exp_own(seed), {29'h0, own});
      end
      bctr_host_i.wr(bctr_pkg::OFS_CHAN, 4'h1, 32'h0000_00a5);
      bctr_host_i.rd(bctr_pkg::OFS_CHAN, rd);
      chk_w("channel lane", {v[31:8], 8'ha5}, rd);
      ta = dev_t;
      @(posedge clk_i);
      chk_d("time step", ta + bctr_pkg::TICK_NS, dev_t);
      // latch ignored without bit 0 or its byte lane
      bctr_host_i.wr(bctr_pkg::OFS_LATCH, 4'hf, 32'hffff_fffe);
      bctr_host_i.wr(bctr_pkg::OFS_LATCH, 4'he, 32'hffff_ffff);
      bctr_host_i.rd(bctr_pkg::OFS_TS_LO, rd);
      chk_w("no latch", 32'h0000_0000, rd);
      ta = dev_t;
      bctr_host_i.read_time(ts);
      tb_t = dev_t;
      chk_w("latch window", 32'h0000_0001,
         {31'h0, ts >= ta && ts <= tb_t && ts % bctr_pkg::TICK_NS == 0});
      // heartbeat: accesses keep it alive, idling lets it expire
      bctr_host_i.wr(bctr_pkg::OFS_OWN, 4'hf, 32'h0000_0001);
      bctr_host_i.wr(bctr_pkg::OFS_HB_PERIOD, 4'hf, 32'h0000_0002);
      for (int i = 0; i < 8; i++) begin
         bctr_host_i.rd(bctr_pkg::OFS_HB_PERIOD, rd);
      end
      chk_w("keepalive", 32'h0000_0000, n_exp);
      chk_w("period", 32'h0000_0002, rd);
      k = 0;
      while (link_def !== 1'b1 && k < 30) begin
         @(posedge clk_i);
         k++;
      end
      chk_w("expiry time", 32'h0000_0001,
         {31'h0, k >= 2 * CPM - 1 && k <= 2 * CPM + 3});
      chk_w("owner cleared", 32'h0000_0000, {29'h0, own});
      @(posedge clk_i);
      chk_w("pulse length", 32'h0000_0000, {31'h0, link_def});
      // reset again in mid-run: written values must fall back
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bctr_host_i.rd(bctr_pkg::OFS_HB_PERIOD, rd);
      chk_w("period after reset", bctr_pkg::HB_PERIOD_RST, rd);
      bctr_host_i.rd(bctr_pkg::OFS_CHAN, rd);
      chk_w("channel after reset", bctr_pkg::CHAN_RST, rd);
      bctr_host_i.rd(bctr_pkg::OFS_TS_LO, rd);
      chk_w("timestamp after reset", 32'h0000_0000, rd);
      chk_w("enables after reset", 32'h0000_0000, {30'h0, hb_en, pk_en});
      stop_test();
   end
endmodule // tb_top

`default_nettype wire

// ### verilog/bctr_regs.sv
// bootstrap control, heartbeat, channel, timestamp and byte-order register bank
//
// What this block does
// RULE_01: config bit 0 enables heartbeat, gated by capability
// RULE_02: config bit 1 packs events, gated; rest zero
// RULE_03: heartbeat expiry restores default link parameters
// RULE_04: every host access restarts heartbeat timer
// RULE_05: heartbeat period 32-bit milliseconds, resets to 3000
// RULE_06: heartbeat period exists only with privilege capability
// RULE_07: channel number resets to zero, uninitialised
// RULE_08: host writes nonzero channel number
// RULE_09: channel register exists only with channel capability
// RULE_10: free-running nanosecond count; latched value reads
// RULE_11: host latches before reading timestamp
// RULE_12: latch bit copies device time, self-clearing
// RULE_13: latch and tick registers follow timestamp capability
// RULE_14: read-only tick size in nanoseconds
// RULE_15: three-bit ownership state, reset available
// RULE_16: heartbeat expiry forces ownership back to available
// RULE_17: ownership register exists only with privilege capability
// RULE_18: host ignores deprecated byte-order location
// RULE_19: byte order reads zero or all ones
// RULE_20: byte order register gated by its capability
// RULE_21: capability bits 1,2,3 gate block registers
// RULE_22: capability bit 12 gates packed events
// RULE_23: heartbeat counts milliseconds, expires at period
// RULE_24: writes to read-only registers are ignored
`timescale 1ns/10ps
`default_nettype none

module bctr_regs #(
   parameter logic [63:0] CAPABILITY = bctr_pkg::CAP_DEFAULT,
   parameter bit LITTLE_ENDIAN = 1'b1,
   parameter int unsigned CYC_PER_MS = bctr_pkg::CYC_PER_MS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire bctr_pkg::bctr_wb_req_s wb_req_i,
   output bctr_pkg::bctr_wb_rsp_s wb_rsp_o,
   output logic heartbeat_enable_o,
   output logic packed_events_enable_o,
   output logic [31:0] async_channel_number_o,
   output logic [2:0] ownership_state_o,
   output logic link_defaults_o,
   output logic [63:0] device_time_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic adr_hit(input logic [11:0] adr, input logic [11:0] ofs);
      adr_hit = (adr[11:2] == ofs[11:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      merge = res;
   endfunction

   localparam logic CAP_OWN = CAPABILITY[bctr_pkg::CAP_OWN_BIT];
   localparam logic CAP_CHAN = CAPABILITY[bctr_pkg::CAP_CHAN_BIT];
   localparam logic CAP_TS = CAPABILITY[bctr_pkg::CAP_TS_BIT];
   localparam logic CAP_ENDIAN = CAPABILITY[bctr_pkg::CAP_ENDIAN_BIT];
   localparam logic CAP_PACKED = CAPABILITY[bctr_pkg::CAP_PACKED_BIT];
   localparam logic [31:0] MS_LAST = 32'(CYC_PER_MS - 1);
   localparam logic [31:0] ENDIAN_VAL = LITTLE_ENDIAN ? bctr_pkg::ENDIAN_LITTLE
                                                      : bctr_pkg::ENDIAN_BIG;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave: one wait state, ack for every address

   bctr_pkg::bctr_bus_e st_r;
   bctr_pkg::bctr_bus_e st_nxt;
   logic [31:0] rdat_r;
   wire logic take;
   wire logic wr;
   wire logic rd;
   wire logic [11:0] adr;
   wire logic [31:0] wdat;
   wire logic [3:0] sel;

   assign take = wb_req_i.cyc && wb_req_i.stb && (st_r == bctr_pkg::BUS_IDLE);
   // a write commits at the edge where the master samples ack, with its request still held
   assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && (st_r == bctr_pkg::BUS_ACK);
   assign rd = take && !wb_req_i.we;
   assign adr = wb_req_i.adr;
   assign wdat = wb_req_i.dat;
   assign sel = wb_req_i.sel;
   assign st_nxt = take ? bctr_pkg::BUS_ACK : bctr_pkg::BUS_IDLE;
   assign wb_rsp_o = '{ack: (st_r == bctr_pkg::BUS_ACK), dat: rdat_r};

   ////////////////////////////////////////////////////////////////////////////
   // address decode, absent registers never hit

   wire logic hit_cfg_lo = adr_hit(adr, bctr_pkg::OFS_CFG_LO);
   wire logic hit_hb = CAP_OWN && adr_hit(adr, bctr_pkg::OFS_HB_PERIOD);     // [RULE_06]
   wire logic hit_chan = CAP_CHAN && adr_hit(adr, bctr_pkg::OFS_CHAN);       // [RULE_09]
   wire logic hit_ts_lo = CAP_TS && adr_hit(adr, bctr_pkg::OFS_TS_LO);       // [RULE_21]
   wire logic hit_ts_hi = CAP_TS && adr_hit(adr, bctr_pkg::OFS_TS_HI);
   wire logic hit_latch = CAP_TS && adr_hit(adr, bctr_pkg::OFS_LATCH);       // [RULE_13]
   wire logic hit_tick_lo = CAP_TS && adr_hit(adr, bctr_pkg::OFS_TICK_LO);   // [RULE_13]
   wire logic hit_tick_hi = CAP_TS && adr_hit(adr, bctr_pkg::OFS_TICK_HI);
   wire logic hit_own = CAP_OWN && adr_hit(adr, bctr_pkg::OFS_OWN);          // [RULE_17]
   wire logic hit_endian = CAP_ENDIAN && adr_hit(adr, bctr_pkg::OFS_ENDIAN); // [RULE_20]

   ////////////////////////////////////////////////////////////////////////////
   // configuration and host-written registers

   logic cfg_hb_r;
   logic cfg_packed_r;
   logic [31:0] hb_period_r;
   logic [31:0] chan_r;
   logic [2:0] own_r;
   wire logic [31:0] cfg_word = {30'h0000_0000, cfg_packed_r, cfg_hb_r};
   wire logic [31:0] cfg_wr = merge(cfg_word, wdat, sel);
   wire logic [31:0] own_wr = merge({29'h0000_0000, own_r}, wdat, sel);
   wire logic expire;

   assign heartbeat_enable_o = cfg_hb_r;
   assign packed_events_enable_o = cfg_packed_r;
   assign async_channel_number_o = chan_r;
   assign ownership_state_o = own_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_hb_r <= 1'b0;
         cfg_packed_r <= 1'b0;
      end else if (wr && hit_cfg_lo) begin
         cfg_hb_r <= cfg_wr[bctr_pkg::CFG_HB_BIT] && CAP_OWN;              // [RULE_01] [RULE_21]
         cfg_packed_r <= cfg_wr[bctr_pkg::CFG_PACKED_BIT] && CAP_PACKED;  // [RULE_02] [RULE_22]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hb_period_r <= bctr_pkg::HB_PERIOD_RST;                           // [RULE_05]
      end else if (wr && hit_hb) begin
         hb_period_r <= merge(hb_period_r, wdat, sel);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_r <= bctr_pkg::CHAN_RST;                                     // [RULE_07]
      end else if (wr && hit_chan) begin
         chan_r <= merge(chan_r, wdat, sel);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_r <= bctr_pkg::OWN_AVAILABLE;                                 // [RULE_15]
      end else if (expire) begin
         own_r <= bctr_pkg::OWN_AVAILABLE;                                 // [RULE_16]
      end else if (wr && hit_own) begin
         own_r <= own_wr[bctr_pkg::OWN_W-1:0];                             // [RULE_15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // heartbeat supervision: millisecond prescaler and elapsed-ms count

   logic [31:0] ms_cnt_r;
   logic [31:0] hb_ms_r;
   logic link_def_r;
   wire logic ms_wrap = (ms_cnt_r == MS_LAST);

   // an access in the same cycle restarts the timer instead of expiring it
   assign expire = cfg_hb_r && !take && (hb_ms_r >= hb_period_r);         // [RULE_23]
   assign link_defaults_o = link_def_r;

   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg_hb_r || take || expire) begin
         ms_cnt_r <= 32'h0000_0000;                                        // [RULE_04]
         hb_ms_r <= 32'h0000_0000;
      end else if (ms_wrap) begin
         ms_cnt_r <= 32'h0000_0000;
         hb_ms_r <= hb_ms_r + 32'h0000_0001;                               // [RULE_23]
      end else begin
         ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_def_r <= 1'b0;
      end else begin
         link_def_r <= expire;                                             // [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // free-running device time and latched timestamp

   logic [63:0] time_ns_r;
   logic [63:0] ts_r;
   wire logic latch_cmd = wr && hit_latch && sel[0] && wdat[bctr_pkg::LATCH_BIT];

   assign device_time_o = time_ns_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         time_ns_r <= 64'h0000_0000_0000_0000;
      end else begin
         time_ns_r <= time_ns_r + bctr_pkg::TICK_NS;                       // [RULE_10]
      end
   end

   // the command bit is not stored, so it needs no clearing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ts_r <= 64'h0000_0000_0000_0000;                                  // [RULE_10]
      end else if (latch_cmd) begin
         ts_r <= time_ns_r;                                                // [RULE_12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read selection; legacy, latch and absent words read zero

   wire logic [31:0] rd_mux =
      hit_cfg_lo ? cfg_word :
      hit_hb ? hb_period_r :
      hit_chan ? chan_r :
      hit_ts_lo ? ts_r[31:0] :                                             // [RULE_10]
      hit_ts_hi ? ts_r[63:32] :
      hit_tick_lo ? bctr_pkg::TICK_NS[31:0] :                              // [RULE_14]
      hit_tick_hi ? bctr_pkg::TICK_NS[63:32] :
      hit_own ? {29'h0000_0000, own_r} :
      hit_endian ? ENDIAN_VAL :                                            // [RULE_19]
      bctr_pkg::WORD_ZERO;                                                 // [RULE_18]

   // read-only words have no write enable above, so writes fall away [RULE_24]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= bctr_pkg::BUS_IDLE;
         rdat_r <= bctr_pkg::WORD_ZERO;
      end else begin
         st_r <= st_nxt;
         rdat_r <= rd ? rd_mux : bctr_pkg::WORD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_latch_write;
      wr && hit_latch && sel[0] && wdat[bctr_pkg::LATCH_BIT];
   endsequence

   sequence s_expiry;
      expire ##1 link_defaults_o;
   endsequence

   AST_HB_GATED: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
      cfg_hb_r |-> CAP_OWN)
      else $error("heartbeat enable set without privilege capability");

   AST_PACKED_GATED: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
      cfg_packed_r |-> CAP_PACKED)
      else $error("packed events enable set without capability");

   AST_EXPIRY_EFFECTS: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
      expire |-> s_expiry ##0 (own_r == bctr_pkg::OWN_AVAILABLE)
         ##1 (link_defaults_o == $past(expire)))
      else $error("expiry did not restore defaults and ownership");

   AST_ACCESS_RESTART: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
      take |=> (hb_ms_r == 32'h0000_0000) && (ms_cnt_r == 32'h0000_0000) && !link_defaults_o)
      else $error("host access did not restart heartbeat");

   AST_PERIOD_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
      $past(rst_i) |-> (hb_period_r == bctr_pkg::HB_PERIOD_RST) && (chan_r == bctr_pkg::CHAN_RST))
      else $error("heartbeat period or channel wrong after reset");

   AST_CHAN_GATED: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
      (chan_r != bctr_pkg::CHAN_RST) |-> CAP_CHAN)
      else $error("channel number written without capability");

   AST_TIME_RUNS: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
      !$past(rst_i) |-> time_ns_r == $past(time_ns_r) + bctr_pkg::TICK_NS)
      else $error("device time did not advance by one tick");

   AST_LATCH_COPY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_12]
      s_latch_write |=> (ts_r == $past(time_ns_r)) ##1 wb_rsp_o.ack == 1'b0)
      else $error("latch did not capture device time");

   AST_TS_READONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_24]
      (wr && (hit_ts_lo || hit_ts_hi) && !latch_cmd) |=> $stable(ts_r))
      else $error("timestamp changed on write");

   AST_OWN_EXPIRE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_16]
      (cfg_hb_r && !take && hb_ms_r >= hb_period_r) |=> own_r == bctr_pkg::OWN_AVAILABLE)
      else $error("ownership not cleared on heartbeat expiry");

   AST_HB_BOUND: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_23]
      (cfg_hb_r && !take && !expire && ms_wrap) |=> hb_ms_r == $past(hb_ms_r) + 32'h0000_0001)
      else $error("heartbeat millisecond count did not step");

   AST_ENDIAN_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_19]
      (rd && hit_endian) |=> wb_rsp_o.ack && (wb_rsp_o.dat == ENDIAN_VAL))
      else $error("byte order read returned wrong value");

   AST_ACK_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
      take |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
      else $error("bus acknowledge not a single cycle");

   AST_WRITE_AT_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      wr |-> wb_rsp_o.ack && $past(take))
      else $error("write committed outside its acknowledge cycle");

   AST_READ_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_rsp_o.ack |-> (wb_rsp_o.dat == bctr_pkg::WORD_ZERO))
      else $error("read data not zero outside acknowledge");

   AST_HB_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
      !cfg_hb_r |-> !expire ##1 (hb_ms_r == 32'h0000_0000))
      else $error("disabled heartbeat still counting or expiring");

   AST_CFG_HI_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
      (rd && adr_hit(adr, bctr_pkg::OFS_CFG_HI)) |=> (wb_rsp_o.dat == bctr_pkg::WORD_ZERO))
      else $error("upper configuration word not zero");

   AST_LINK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
      link_defaults_o |-> $past(expire))
      else $error("link defaults pulse without heartbeat expiry");

   AST_LATCH_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_12]
      (wr && hit_latch && !latch_cmd) |=> $stable(ts_r))
      else $error("timestamp changed without latch bit");

   AST_TICK_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
      (rd && hit_tick_lo) |=> wb_rsp_o.ack && (wb_rsp_o.dat == bctr_pkg::TICK_NS[31:0]))
      else $error("tick size read returned wrong value");

   AST_OWN_GATED: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_17]
      (own_r != bctr_pkg::OWN_AVAILABLE) |-> CAP_OWN)
      else $error("ownership state set without privilege capability");

endmodule // bctr_regs

`default_nettype wire
